// ==== src/ppoc_top.sv ====
// pwm pin pair output stage with axi4-lite control register
`default_nettype none
// Contract
// - normal fault mode with current limit: high from limit bit 1, low from bit 0
// - independent fault mode ignores both current-limit state bits
// - swap set routes high signal to low pin and low signal to high pin
// - override sync set: override data changes applied on time base sync pulse
// - override sync clear: override data changes apply at next clock
// - limit and fault bits are active/inactive states, polarity decides levels
// - polarity bit 1 makes the pin active-low, 0 active-high
module ppoc_top
    import ppoc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pwm generator and fault inputs
    input  wire logic        pwm_gen_high,
    input  wire logic        pwm_gen_low,
    input  wire logic        timebase_sync,
    input  wire logic        fault_active,
    input  wire logic        current_limit_active,
    input  wire logic        fault_mode_independent,
    // pins
    output logic             high_side_output,
    output logic             low_side_output,
    output logic             pwm_owns_high,
    output logic             pwm_owns_low
);
    ppoc_state_t st;
    ppoc_state_t next_st;

    function automatic logic [31:0] read_mux(input logic [3:0] a, input ppoc_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == ADDR_IOCON)
            v = {16'h0000, s.iocon};
        else if (a == ADDR_STATUS)
            v = {28'h000_0000, s.pins.high, s.pins.low, s.ovr_live};
        return v;
    endfunction : read_mux

    function automatic logic addr_ok(input logic [3:0] a);
        return (a == ADDR_IOCON) || (a == ADDR_STATUS);
    endfunction : addr_ok

    logic       wr_fire;
    logic [1:0] act;
    logic [1:0] lvl;

    always_comb begin
        next_st = st;
        s_axi_awready = !st.aw_got && !st.bvalid;
        s_axi_wready  = !st.w_got && !st.bvalid;
        s_axi_arready = !st.rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        wr_fire = st.aw_got && st.w_got;
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = addr_ok(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (st.aw_addr == ADDR_IOCON) begin
                if (st.w_strb[0])
                    next_st.iocon[7:0] = st.w_data[7:0];
                if (st.w_strb[1])
                    next_st.iocon[15:8] = st.w_data[15:8];
            end
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_mux(s_axi_araddr, st);
            next_st.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        ////////////////////////////////////////////////////////////////////////////////
        // override data: live copy updated on sync or next clock
        if (!st.iocon[BIT_OVSYNC] || timebase_sync)
            next_st.ovr_live = st.iocon[BIT_OVRD1:BIT_OVRD0];
        // active state selection, override over fault over current limit
        act = {pwm_gen_high, pwm_gen_low};
        if (current_limit_active && !fault_mode_independent)
            act = st.iocon[BIT_CLD1:BIT_CLD0];
        if (fault_active)
            act = st.iocon[BIT_FLTD1:BIT_FLTD0];
        if (st.iocon[BIT_OVRENH])
            act[1] = st.ovr_live[1];
        if (st.iocon[BIT_OVRENL])
            act[0] = st.ovr_live[0];
        // polarity then swap
        lvl = act ^ {st.iocon[BIT_POLHI], st.iocon[BIT_POLL]};
        if (st.iocon[BIT_SWAP]) begin
            next_st.pins.high = lvl[0];
            next_st.pins.low  = lvl[1];
        end else begin
            next_st.pins.high = lvl[1];
            next_st.pins.low  = lvl[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st       <= '0;
            st.iocon <= IOCON_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rdata      = st.rdata;
    assign s_axi_rresp      = st.rresp;
    assign high_side_output = st.pins.high;
    assign low_side_output  = st.pins.low;
    assign pwm_owns_high    = st.iocon[BIT_PENH];
    assign pwm_owns_low     = st.iocon[BIT_PENL];

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_cl_normal;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && current_limit_active && !fault_mode_independent && !fault_active
         && !st.iocon[BIT_OVRENH] && !st.iocon[BIT_SWAP])
        |=> (high_side_output == ($past(st.iocon[BIT_CLD1]) ^ $past(st.iocon[BIT_POLHI])));
    endproperty
    a_cl_normal: assert property (p_cl_normal) else $error("limit state not on high pin");

    property p_cl_indep;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && fault_mode_independent && !fault_active && st.iocon[BIT_OVRENH:BIT_OVRENL] == 2'b00
         && !st.iocon[BIT_SWAP] && !st.iocon[BIT_POLL])
        |=> (low_side_output == $past(pwm_gen_low));
    endproperty
    a_cl_indep: assert property (p_cl_indep) else $error("limit bits used in independent mode");

    property p_swap;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && st.iocon[BIT_SWAP] && st.iocon[BIT_OVRENH:BIT_OVRENL] == 2'b00
         && !fault_active && !current_limit_active && st.iocon[BIT_POLL] == 1'b0)
        |=> (high_side_output == $past(pwm_gen_low));
    endproperty
    a_swap: assert property (p_swap) else $error("swap routing wrong");

    property p_ovsync_hold;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && st.iocon[BIT_OVSYNC] && !timebase_sync) |=> $stable(st.ovr_live);
    endproperty
    a_ovsync_hold: assert property (p_ovsync_hold) else $error("override moved without sync");

    property p_ovsync_off;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && !st.iocon[BIT_OVSYNC])
        |=> (st.ovr_live == $past(st.iocon[BIT_OVRD1:BIT_OVRD0]));
    endproperty
    a_ovsync_off: assert property (p_ovsync_off) else $error("override not applied next clock");

    property p_fault;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && fault_active && !st.iocon[BIT_OVRENL] && !st.iocon[BIT_SWAP])
        |=> (low_side_output == ($past(st.iocon[BIT_FLTD0]) ^ $past(st.iocon[BIT_POLL])));
    endproperty
    a_fault: assert property (p_fault) else $error("fault state level wrong");

    property p_ovr_pol;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && st.iocon[BIT_OVRENH] && !st.iocon[BIT_SWAP])
        |=> (high_side_output == ($past(st.ovr_live[1]) ^ $past(st.iocon[BIT_POLHI])));
    endproperty
    a_ovr_pol: assert property (p_ovr_pol) else $error("override or polarity wrong");

    property p_bresp;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && st.aw_got && st.w_got) |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response missing");

    property p_cl_low;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && current_limit_active && !fault_mode_independent && !fault_active
         && !st.iocon[BIT_OVRENL] && !st.iocon[BIT_SWAP])
        |=> (low_side_output == ($past(st.iocon[BIT_CLD0]) ^ $past(st.iocon[BIT_POLL])));
    endproperty
    a_cl_low: assert property (p_cl_low) else $error("limit state not on low pin");

    // override data gets polarity first, then lands on the swapped pin
    property p_order;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && st.iocon[BIT_OVRENH] && st.iocon[BIT_SWAP])
        |=> (low_side_output == ($past(st.ovr_live[1]) ^ $past(st.iocon[BIT_POLHI])));
    endproperty
    a_order: assert property (p_order) else $error("override polarity swap order wrong");
endmodule : ppoc_top
`default_nettype wire

// ==== src/ppoc_pkg.sv ====
// package for the pwm pin output control block
`default_nettype none
package ppoc_pkg;
    // register byte addresses
    localparam logic [3:0]  ADDR_IOCON  = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h4;
    localparam logic [15:0] IOCON_RESET = 16'h0000;
    // control field positions
    localparam int BIT_PENH    = 15;
    localparam int BIT_PENL    = 14;
    localparam int BIT_POLHI   = 13;
    localparam int BIT_POLL    = 12;
    localparam int BIT_OVRENH  = 9;
    localparam int BIT_OVRENL  = 8;
    localparam int BIT_OVRD1   = 7;
    localparam int BIT_OVRD0   = 6;
    localparam int BIT_FLTD1   = 5;
    localparam int BIT_FLTD0   = 4;
    localparam int BIT_CLD1    = 3;
    localparam int BIT_CLD0    = 2;
    localparam int BIT_SWAP    = 1;
    localparam int BIT_OVSYNC  = 0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       high;
        logic       low;
    } ppoc_pair_t;

    typedef struct packed {
        logic [15:0] iocon;
        logic [1:0]  ovr_live;
        ppoc_pair_t  pins;
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ppoc_state_t;
endpackage : ppoc_pkg
`default_nettype wire

// ==== bench/ppoc_power_stage.sv ====
// power stage model seen from the pwm pin pair
`default_nettype none
module ppoc_power_stage (
    // pins from the pin pair
    input  wire logic       pin_h,
    input  wire logic       pin_l,
    input  wire logic       own_h,
    input  wire logic       own_l,
    // switch gate drive
    output logic [1:0]      gate
);
    // gpio-owned pins leave the switch off
    assign gate = {pin_h & own_h, pin_l & own_l};
endmodule : ppoc_power_stage
`default_nettype wire

// ==== bench/ppoc_top_tb_top.sv ====
// self-checking bench for the pwm pin output control block
`default_nettype none
module ppoc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ppoc_pkg::*;
    logic        aclk, rstn, awv, wv, bry, arv, rry, gh, gl, ts, fa, cl, ind, ce;
    logic        awr, wrd, bv, arr, rv, ph, pl, oh, ol;
    logic [3:0]  awa, ara;
    logic [31:0] wd, rdat, got;
    logic [1:0]  br, rrsp, resp, ov, gate, e;
    logic [15:0] cur;
    logic [4:0]  t;
    int          errors, comparisons, i, k;

    ppoc_top u_ppoc_top (.aclk(aclk), .aresetn(rstn), .clk_en(ce),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .pwm_gen_high(gh), .pwm_gen_low(gl), .timebase_sync(ts),
        .fault_active(fa), .current_limit_active(cl), .fault_mode_independent(ind),
        .high_side_output(ph), .low_side_output(pl), .pwm_owns_high(oh), .pwm_owns_low(ol));
    ppoc_power_stage u_ppoc_power_stage (.pin_h(ph), .pin_l(pl), .own_h(oh), .own_l(ol),
        .gate(gate));

    always #10 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input bit wr, input logic [3:0] a, input logic [31:0] d);
        logic [4:0] pend;
        pend = wr ? 5'b11100 : 5'b00011;
        @(posedge aclk);
        if (wr) begin
            awa <= a;
            wd  <= d;
        end else begin
            ara <= a;
        end
        {awv, wv, bry, arv, rry} <= pend;
        // pend mirrors the driven valids and readies, never stale
        for (i = 0; i < 40 && pend != 5'b00000; i++) begin
            @(negedge aclk);
            t = pend & {awr, wrd, bv, arr, rv};
            if (t[2]) resp = br;
            if (t[0]) {resp, got} = {rrsp, rdat};
            pend = pend & ~t;
            @(posedge aclk);
            {awv, wv, bry, arv, rry} <= pend;
        end
        if (pend != 5'b00000) begin
            errors++;
            close_out();
        end
    endtask : xfer

    // override, fault, limit, generator; then polarity; then swap
    function automatic logic [1:0] exp_pins();
        logic h;
        logic l;
        h = cur[9] ? ov[1] : fa ? cur[5] : (cl && !ind) ? cur[3] : gh;
        l = cur[8] ? ov[0] : fa ? cur[4] : (cl && !ind) ? cur[2] : gl;
        h = h ^ cur[13];
        l = l ^ cur[12];
        return cur[1] ? {l, h} : {h, l};
    endfunction : exp_pins

    task automatic cfg(input logic [15:0] c);
        xfer(1'b1, ADDR_IOCON, {16'h0000, c});
        chk(resp, RESP_OKAY);
        cur = c;
        if (!c[0]) ov = c[7:6];
    endtask : cfg

    task automatic pins;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        e = exp_pins();
        chk({ph, pl}, e);
        chk(gate, e & {cur[15], cur[14]});
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(got, {28'h0, e, ov});
    endtask : pins

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aclk, rstn, awv, wv, bry, arv, rry, gh, gl, ts, fa, cl, ind} = '0;
        {awa, ara, wd, errors, comparisons, ov, cur} = '0;
        ce = 1'b1;
        void'($urandom(33));
        repeat (6) @(posedge aclk);
        rstn <= 1'b1;
        xfer(1'b0, ADDR_IOCON, 32'h0);
        chk(got, {16'h0000, IOCON_RESET});
        pins();
        xfer(1'b0, 4'hc, 32'h0);
        chk(got, 32'h0);
        chk(resp, RESP_SLVERR);
        xfer(1'b1, ADDR_STATUS, 32'hf);
        chk(resp, RESP_OKAY);
        xfer(1'b0, ADDR_IOCON, 32'h0);
        chk(got, {16'h0000, IOCON_RESET});
        $display("reset and map test done");
        for (k = 0; k < 80; k++) begin
            {gh, gl, fa, cl, ind} <= 5'($urandom);
            cfg(16'($urandom) & 16'hf3fe);
            pins();
        end
        $display("random test done");
        for (k = 0; k < 2; k++) begin
            {gh, gl, fa, cl, ind} <= {4'b1001, k[0]};
            cfg(16'hc004);
            pins();
        end
        $display("limit mode test done");
        // clock enable low freezes the pins against an input change
        e = exp_pins();
        ce  <= 1'b0;
        ind <= 1'b0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({ph, pl}, e);
        @(posedge aclk);
        ce <= 1'b1;
        pins();
        $display("clock enable test done");
        cfg(16'h0300);
        cfg(16'h03c1);
        pins();
        ts <= 1'b1;
        @(posedge aclk);
        ts <= 1'b0;
        ov = 2'b11;
        pins();
        $display("override sync test done");
        close_out();
    end
endmodule : ppoc_top_tb_top
`default_nettype wire
